// file: design/vfe_frontend_regs.sv
// Front-end configuration register bank on an AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module vfe_frontend_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        clamp_pin,
	output var  logic        offset_range,
	output var  logic [9:0]  red_dac_code,
	output var  logic [9:0]  green_dac_code,
	output var  logic [9:0]  blue_dac_code,
	output var  logic [3:0]  filter_corner_select,
	output var  logic [3:0]  peaking_select,
	output var  logic [13:0] line_total,
	output var  logic [5:0]  sampling_phase,
	output var  logic [7:0]  coast_lines_before,
	output var  logic [7:0]  coast_lines_after,
	output var  logic        auto_black_off
);
	localparam int RW = vfe_regs_pkg::REG_WIDTH;
	localparam int NC = vfe_regs_pkg::CHANNELS;
	localparam int DW = vfe_regs_pkg::DAC_WIDTH;

	logic [vfe_regs_pkg::REG_COUNT-1:0][RW-1:0] regs;
	logic [vfe_regs_pkg::REG_COUNT-1:0][RW-1:0] next_regs;
	logic [3:0]       wr_idx;
	logic [3:0]       next_wr_idx;
	logic             wr_pend;
	logic             next_wr_pend;
	logic             next_wr_pend_hit;
	logic [31:0]      next_hrdata;
	logic             addr_valid;
	logic [3:0]       addr_idx;
	logic             addr_mapped;
	logic             clamp_level;
	logic             clamp_rise;
	logic             ext_clamp;
	logic             apply_now;
	logic [DW-1:0]    applied   [NC];
	logic [DW-1:0]    target    [NC];
	logic [DW-1:0]    next_applied [NC];

	////////////////////////////////////////////////////////////////////////////
	// Bus address phase and write capture.

	assign addr_valid  = hsel & htrans[1] & hready;
	assign addr_idx    = haddr[vfe_regs_pkg::IDX_MSB:vfe_regs_pkg::IDX_LSB];
	assign addr_mapped = (haddr[31:vfe_regs_pkg::IDX_MSB+1] == '0)
		&& (addr_idx <= vfe_regs_pkg::IDX_LAST);

	always_comb begin
		next_wr_pend = 1'b0;
		next_wr_idx  = wr_idx;
		if (hready) begin
			next_wr_pend = addr_valid & hwrite & addr_mapped;
			next_wr_idx  = addr_idx;
		end else begin
			next_wr_pend = wr_pend;
		end
	end
	assign next_wr_pend_hit = wr_pend;

	always_comb begin
		next_regs = regs;
		if (next_wr_pend_hit) begin
			next_regs[wr_idx] = hwdata[RW-1:0] & vfe_regs_pkg::REG_MASK[wr_idx];
		end
	end

	always_comb begin
		next_hrdata = '0;
		if (addr_valid && !hwrite && addr_mapped) begin
			next_hrdata[RW-1:0] = next_regs[addr_idx];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regs      <= vfe_regs_pkg::REG_RESET;
			wr_pend   <= 1'b0;
			wr_idx    <= '0;
			hrdata    <= '0;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			regs      <= next_regs;
			wr_pend   <= next_wr_pend;
			wr_idx    <= next_wr_idx;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field outputs.

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			offset_range         <= 1'b0;
			filter_corner_select <= '0;
			peaking_select       <= '0;
			line_total           <= '0;
			sampling_phase       <= '0;
			coast_lines_before   <= '0;
			coast_lines_after    <= '0;
			auto_black_off       <= 1'b0;
		end else begin
			offset_range <= regs[vfe_regs_pkg::IDX_OFFSET_DAC][vfe_regs_pkg::RANGE_BIT];
			filter_corner_select <= regs[vfe_regs_pkg::IDX_FILTER_CORNER_SELECT]
				[vfe_regs_pkg::CORNER_LSB +: vfe_regs_pkg::CORNER_WIDTH];
			peaking_select <= regs[vfe_regs_pkg::IDX_FILTER_CORNER_SELECT]
				[vfe_regs_pkg::PEAK_LSB +: vfe_regs_pkg::PEAK_WIDTH];
			line_total <= {regs[vfe_regs_pkg::IDX_TOTAL_HIGH][vfe_regs_pkg::TOTAL_HIGH_WIDTH-1:0],
				regs[vfe_regs_pkg::IDX_TOTAL_LOW]};
			sampling_phase <= regs[vfe_regs_pkg::IDX_PHASE][vfe_regs_pkg::PHASE_WIDTH-1:0];
			coast_lines_before <= regs[vfe_regs_pkg::IDX_COAST_BEFORE];
			coast_lines_after <= regs[vfe_regs_pkg::IDX_COAST_AFTER];
			auto_black_off <= regs[vfe_regs_pkg::IDX_CONTROL][vfe_regs_pkg::CTRL_BLACK_OFF_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Offset DAC codes and clamp-timed update.

	vfe_pin_sync u_clamp_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (clamp_pin),
		.level   (clamp_level),
		.rise    (clamp_rise)
	);

	assign ext_clamp = regs[vfe_regs_pkg::IDX_CONTROL][vfe_regs_pkg::CTRL_EXT_CLAMP_BIT];
	assign apply_now = ~ext_clamp | clamp_rise;

	genvar ch;
	generate
		for (ch = 0; ch < NC; ch++) begin : g_chan
			localparam int LSB_POS = vfe_regs_pkg::DAC_LSB_POS + vfe_regs_pkg::DAC_LSB_WIDTH * ch;
			assign target[ch] = regs[vfe_regs_pkg::IDX_CONTROL][vfe_regs_pkg::CTRL_BLACK_OFF_BIT]
				? {regs[ch], regs[vfe_regs_pkg::IDX_OFFSET_DAC][LSB_POS +: vfe_regs_pkg::DAC_LSB_WIDTH]}
				: vfe_regs_pkg::DAC_MID_CODE;
			always_comb begin
				next_applied[ch] = applied[ch];
				if (apply_now) begin
					next_applied[ch] = target[ch];
				end
			end
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					applied[ch] <= vfe_regs_pkg::DAC_MID_CODE;
				end else begin
					applied[ch] <= next_applied[ch];
				end
			end
		end
	endgenerate

	assign red_dac_code   = applied[0];
	assign green_dac_code = applied[1];
	assign blue_dac_code  = applied[2];

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_reserved_zero;
		@(posedge hclk) disable iff (!hresetn) hrdata[31:RW] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read bits set");

	property p_write_store;
		@(posedge hclk) disable iff (!hresetn)
		wr_pend |=> regs[$past(wr_idx)] ==
			($past(hwdata[RW-1:0]) & vfe_regs_pkg::REG_MASK[$past(wr_idx)]);
	endproperty
	a_write_store: assert property (p_write_store) else $error("write not stored");

	property p_range;
		@(posedge hclk) disable iff (!hresetn)
		$rose(regs[vfe_regs_pkg::IDX_OFFSET_DAC][0]) |=> offset_range;
	endproperty
	a_range: assert property (p_range) else $error("range output lags");

	property p_corner;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> filter_corner_select == $past(regs[vfe_regs_pkg::IDX_FILTER_CORNER_SELECT][3:0]);
	endproperty
	a_corner: assert property (p_corner) else $error("corner output wrong");

	property p_phase;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> sampling_phase == $past(regs[vfe_regs_pkg::IDX_PHASE][5:0]);
	endproperty
	a_phase: assert property (p_phase) else $error("phase output wrong");

	property p_coast;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> coast_lines_before == $past(regs[vfe_regs_pkg::IDX_COAST_BEFORE]);
	endproperty
	a_coast: assert property (p_coast) else $error("pre-coast output wrong");

	property p_post;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> coast_lines_after == $past(regs[vfe_regs_pkg::IDX_COAST_AFTER]);
	endproperty
	a_post: assert property (p_post) else $error("post-coast output wrong");

	property p_manual;
		@(posedge hclk) disable iff (!hresetn)
		(!ext_clamp && regs[vfe_regs_pkg::IDX_CONTROL][0]) |=>
			red_dac_code[DW-1:2] == $past(regs[vfe_regs_pkg::IDX_RED_OFFSET]);
	endproperty
	a_manual: assert property (p_manual) else $error("manual upper bits wrong");

	property p_low_bits;
		@(posedge hclk) disable iff (!hresetn)
		(!ext_clamp && regs[vfe_regs_pkg::IDX_CONTROL][0]) |=>
			blue_dac_code[1:0] == $past(regs[vfe_regs_pkg::IDX_OFFSET_DAC][7:6]);
	endproperty
	a_low_bits: assert property (p_low_bits) else $error("low offset bits wrong");

	property p_clamp_hold;
		@(posedge hclk) disable iff (!hresetn)
		(ext_clamp && !clamp_rise) |=> $stable(green_dac_code);
	endproperty
	a_clamp_hold: assert property (p_clamp_hold) else $error("code moved without clamp");

	property p_clamp_take;
		@(posedge hclk) disable iff (!hresetn)
		clamp_rise |=> green_dac_code == $past(target[1]);
	endproperty
	a_clamp_take: assert property (p_clamp_take) else $error("code not taken at clamp");

	property p_bus_ready;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> (hreadyout && !hresp);
	endproperty
	a_bus_ready: assert property (p_bus_ready) else $error("bus not ready or error");

	property p_unmapped_read;
		@(posedge hclk) disable iff (!hresetn)
		(addr_valid && !hwrite && !addr_mapped) |=> hrdata == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_unmapped_write;
		@(posedge hclk) disable iff (!hresetn)
		(addr_valid && hwrite && !addr_mapped) |=> !wr_pend;
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write taken");

	property p_range_fall;
		@(posedge hclk) disable iff (!hresetn)
		$fell(regs[vfe_regs_pkg::IDX_OFFSET_DAC][vfe_regs_pkg::RANGE_BIT]) |=> !offset_range;
	endproperty
	a_range_fall: assert property (p_range_fall) else $error("range output stuck");

	property p_peaking;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> peaking_select == $past(regs[vfe_regs_pkg::IDX_FILTER_CORNER_SELECT]
			[vfe_regs_pkg::PEAK_LSB +: vfe_regs_pkg::PEAK_WIDTH]);
	endproperty
	a_peaking: assert property (p_peaking) else $error("peaking output wrong");

	property p_total;
		@(posedge hclk) disable iff (!hresetn)
		hresetn |=> line_total == $past({regs[vfe_regs_pkg::IDX_TOTAL_HIGH]
			[vfe_regs_pkg::TOTAL_HIGH_WIDTH-1:0], regs[vfe_regs_pkg::IDX_TOTAL_LOW]});
	endproperty
	a_total: assert property (p_total) else $error("line total output wrong");

	property p_auto_mid;
		@(posedge hclk) disable iff (!hresetn)
		(!regs[vfe_regs_pkg::IDX_CONTROL][vfe_regs_pkg::CTRL_BLACK_OFF_BIT] && !ext_clamp)
			|=> red_dac_code == vfe_regs_pkg::DAC_MID_CODE;
	endproperty
	a_auto_mid: assert property (p_auto_mid) else $error("automatic mode code wrong");

	property p_rise_pulse;
		@(posedge hclk) disable iff (!hresetn)
		clamp_rise |=> !clamp_rise;
	endproperty
	a_rise_pulse: assert property (p_rise_pulse) else $error("clamp edge held too long");

	c_write: cover property (@(posedge hclk) disable iff (!hresetn) wr_pend);
	c_read: cover property (@(posedge hclk) disable iff (!hresetn)
		addr_valid && !hwrite && addr_mapped);
	c_clamp: cover property (@(posedge hclk) disable iff (!hresetn) ext_clamp && clamp_rise);
	c_level: cover property (@(posedge hclk) disable iff (!hresetn) $fell(clamp_level));

endmodule : vfe_frontend_regs
`default_nettype wire

// file: design/vfe_regs_pkg.sv
// Constants for the video front-end configuration register bank.
// How it works
// - Bit 0 of the offset DAC configuration register picks a half-scale (0) or quarter-scale (1) offset range.
// - Two low offset bits per channel (red 3..2, green 5..4, blue 7..6) join the 8-bit channel offset into a 10-bit code.
// - Bits 3..0 of the filter_corner_select register pick the lowpass corner, 000b for 100MHz up to 111b for 780MHz, the default.
// - The 6-bit sampling phase moves the sample point by 5.625 degrees per step.
// - The 8-bit pre-coast field is the number of lines the PLL coasts before vertical sync.
// - The 8-bit post-coast field is the number of lines the PLL coasts after vertical sync starts.
// - With automatic black level off, each 8-bit channel offset drives the top eight bits of the DAC code.
// - In external clamp mode a new DAC code takes effect only at the leading edge of the clamp pulse.
package vfe_regs_pkg;

	localparam int          REG_COUNT         = 11;
	localparam int          REG_WIDTH         = 8;
	localparam int          IDX_LSB           = 2;
	localparam int          IDX_MSB           = 5;

	localparam logic [3:0]  IDX_RED_OFFSET    = 4'h0;
	localparam logic [3:0]  IDX_GREEN_OFFSET  = 4'h1;
	localparam logic [3:0]  IDX_BLUE_OFFSET   = 4'h2;
	localparam logic [3:0]  IDX_OFFSET_DAC    = 4'h3;
	localparam logic [3:0]  IDX_FILTER_CORNER_SELECT     = 4'h4;
	localparam logic [3:0]  IDX_TOTAL_HIGH    = 4'h5;
	localparam logic [3:0]  IDX_TOTAL_LOW     = 4'h6;
	localparam logic [3:0]  IDX_PHASE         = 4'h7;
	localparam logic [3:0]  IDX_COAST_BEFORE  = 4'h8;
	localparam logic [3:0]  IDX_COAST_AFTER   = 4'h9;
	localparam logic [3:0]  IDX_CONTROL       = 4'hA;
	localparam logic [3:0]  IDX_LAST          = 4'hA;

	// Writable bits of each register, index 10 leftmost.
	localparam logic [REG_COUNT-1:0][REG_WIDTH-1:0] REG_MASK = {
		8'h03, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hFF
	};
	localparam logic [REG_COUNT-1:0][REG_WIDTH-1:0] REG_RESET = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h27, 8'h00, 8'h80, 8'h80, 8'h80
	};

	localparam int          RANGE_BIT         = 0;
	localparam int          DAC_LSB_POS       = 2;
	localparam int          DAC_LSB_WIDTH     = 2;
	localparam int          DAC_WIDTH         = 10;
	localparam logic [9:0]  DAC_MID_CODE      = 10'h200;
	localparam int          CORNER_LSB        = 0;
	localparam int          CORNER_WIDTH      = 4;
	localparam int          PEAK_LSB          = 4;
	localparam int          PEAK_WIDTH        = 4;
	localparam int          TOTAL_HIGH_WIDTH  = 6;
	localparam int          TOTAL_WIDTH       = 14;
	localparam int          PHASE_WIDTH       = 6;
	localparam int          CTRL_BLACK_OFF_BIT = 0;
	localparam int          CTRL_EXT_CLAMP_BIT = 1;
	localparam int          CHANNELS          = 3;

endpackage : vfe_regs_pkg

// file: design/vfe_pin_sync.sv
// Three-stage synchroniser with agreement filter for an external pin.
`timescale 1ns/100ps
`default_nettype none
module vfe_pin_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_in,
	output var  logic level,
	output var  logic rise
);
	logic       stage1;
	logic       stage2;
	logic       stage3;
	logic       next_level;
	logic       next_rise;

	// The level only moves once the second and third stages agree.
	always_comb begin
		next_level = level;
		if (stage2 == stage3) begin
			next_level = stage3;
		end
		next_rise = next_level & ~level;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level  <= 1'b0;
			rise   <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
			rise   <= next_rise;
		end
	end
endmodule : vfe_pin_sync
`default_nettype wire

// file: tb/vfe_clamp_model.sv
// Clamp pulse source standing in for the front-end clamp generator.
`timescale 1ns/100ps
`default_nettype none
module vfe_clamp_model (
	input  wire logic hclk,
	input  wire logic fire,
	output var  logic clamp_pin
);
	// The pin is driven low between pulses and moves off the clock edge.
	// clamp leading edge
	initial begin
		clamp_pin = 1'b0;
		forever begin
			@(posedge hclk iff fire);
			#3 clamp_pin = 1'b1;
			repeat (4) @(posedge hclk);
			#3 clamp_pin = 1'b0;
		end
	end
endmodule : vfe_clamp_model
`default_nettype wire

// file: tb/vfe_frontend_regs_tb.sv
// Self-checking bench for the front-end configuration register bank.
`timescale 1ns/100ps
`default_nettype none
module vfe_frontend_regs_tb;
	logic        hclk, hresetn, hsel, hwrite, fire, hreadyout, hresp, clamp_pin;
	logic        offset_range, auto_black_off;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [9:0]  red_dac_code, green_dac_code, blue_dac_code;
	logic [3:0]  filter_corner_select, peaking_select;
	logic [13:0] line_total;
	logic [5:0]  sampling_phase;
	logic [7:0]  coast_lines_before, coast_lines_after;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;

	vfe_frontend_regs uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.clamp_pin(clamp_pin), .offset_range(offset_range),
		.red_dac_code(red_dac_code), .green_dac_code(green_dac_code),
		.blue_dac_code(blue_dac_code), .filter_corner_select(filter_corner_select),
		.peaking_select(peaking_select), .line_total(line_total),
		.sampling_phase(sampling_phase), .coast_lines_before(coast_lines_before),
		.coast_lines_after(coast_lines_after), .auto_black_off(auto_black_off)
	);
	vfe_clamp_model clamp_src (.hclk(hclk), .fire(fire), .clamp_pin(clamp_pin));

	////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			print_verdict;
		end
	end

	////////////////////////////////////////
	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single AHB-Lite transfer, entered and left at a rising edge.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask : rd

	task nap(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : nap

	////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		fire = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 11; i++) begin
			rd(32'(i * 4), 32'(vfe_regs_pkg::REG_RESET[i]));
		end
		nap(1);
		chk(32'(filter_corner_select), 32'h7);
		chk(32'(line_total), 32'h200);
		chk(32'(hresp), 32'h0);
		chk(32'(red_dac_code), 32'h200);
		$display("test reset values done");
		@(posedge hclk);
		for (int i = 0; i < 11; i++) begin
			// Peaking stays legal and the line total never drops below its minimum.
			wr(32'(i * 4), (i == vfe_regs_pkg::IDX_FILTER_CORNER_SELECT) ? 32'hFFFF_FF2F : 32'hFFFF_FFFF);
			rd(32'(i * 4), ((i == vfe_regs_pkg::IDX_FILTER_CORNER_SELECT) ? 32'h2F : 32'hFF)
				& 32'(vfe_regs_pkg::REG_MASK[i]));
			wr(32'(i * 4), 32'h2);
			rd(32'(i * 4), 32'h2 & 32'(vfe_regs_pkg::REG_MASK[i]));
		end
		wr(32'h2C, 32'hFF);
		rd(32'h2C, 32'h0);
		wr(32'h40, 32'h5A);
		rd(32'h00, 32'h2);
		$display("test access masks done");
		wr(32'h0C, 32'hDB);
		wr(32'h14, 32'h2A);
		wr(32'h18, 32'h5C);
		wr(32'h1C, 32'h2B);
		wr(32'h20, 32'h81);
		wr(32'h24, 32'h7E);
		wr(32'h28, 32'h1);
		wr(32'h00, 32'hA5);
		wr(32'h04, 32'h3C);
		wr(32'h08, 32'hFF);
		nap(3);
		chk(32'(offset_range), 32'h1);
		chk(32'(line_total), 32'h2A5C);
		chk(32'(sampling_phase), 32'h2B);
		chk(32'(coast_lines_before), 32'h81);
		chk(32'(coast_lines_after), 32'h7E);
		chk(32'(auto_black_off), 32'h1);
		chk(32'(red_dac_code), 32'h296);
		chk(32'(green_dac_code), 32'hF1);
		chk(32'(blue_dac_code), 32'h3FF);
		@(posedge hclk);
		for (int k = 0; k < 8; k++) begin
			wr(32'h10, 32'((k % 3) * 16 + k));
			nap(2);
			chk(32'(filter_corner_select), 32'(k));
			chk(32'(peaking_select), 32'(k % 3));
			@(posedge hclk);
		end
		$display("test field outputs done");
		wr(32'h28, 32'h3);
		wr(32'h00, 32'h12);
		nap(8);
		chk(32'(red_dac_code), 32'h296);
		@(posedge hclk);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		nap(10);
		chk(32'(red_dac_code), 32'h4A);
		@(posedge hclk);
		wr(32'h28, 32'h0);
		nap(3);
		chk(32'(red_dac_code), 32'h200);
		$display("test clamp update done");
		print_verdict;
	end
endmodule : vfe_frontend_regs_tb
`default_nettype wire
